//--- rmsp_defines.svh
// Timing counts and field positions for the reset and mode-select pin control block
`ifndef RMSP_DEFINES_SVH
`define RMSP_DEFINES_SVH
`define RMSP_RST_PULSE_CYC 34
`define RMSP_BIT_CYC 16
`define RMSP_CAUSE_W 4
`define RMSP_CAUSE_EXT 0
`define RMSP_CAUSE_POR 1
`define RMSP_CAUSE_LVD 2
`define RMSP_CAUSE_INT 3
`endif

//--- rmsp_pkg.sv
// Types shared by the reset and mode-select pin control block
package rmsp_pkg;
  // Reset sequencer states, one-hot
  typedef enum logic [2:0]
  {
    RMSP_ST_RUN = 3'b001,
    RMSP_ST_PULL = 3'b010,
    RMSP_ST_WAIT = 3'b100
  } rmsp_state_type;
  // Per-pin software configuration
  typedef struct packed
  {
    logic dir_out;
    logic strong_drive;
    logic slew_limit;
    logic pull_up;
  } rmsp_pincfg_type;
endpackage : rmsp_pkg

//--- rmsp_core.sv
// Reset pin sequencer, mode-select capture, debug line driver and port pin control
`timescale 1ns/1ps
`default_nettype none
`include "rmsp_defines.svh"
////////////////////////////////////////////////////////////////////////////////
module rmsp_core
  import rmsp_pkg::*;
#(
  parameter int NPINS = 8
)
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_reset_pin,
  input wire logic [`RMSP_CAUSE_W-1:0] i_int_reset,
  input wire logic i_clear_cause,
  input wire logic i_debug_pin,
  input wire logic i_dbg_clk_en,
  input wire logic i_dbg_tx_en,
  input wire logic i_dbg_tx_bit,
  input wire logic i_clk_ext_sel,
  input wire logic i_cfg_we,
  input wire logic [NPINS-1:0] i_cfg_dir,
  input wire logic [NPINS-1:0] i_cfg_drive,
  input wire logic [NPINS-1:0] i_cfg_slew,
  input wire logic [NPINS-1:0] i_cfg_pull,
  input wire logic [NPINS-1:0] i_port_out,
  input wire logic [NPINS-1:0] i_per_own,
  input wire logic [NPINS-1:0] i_per_oe,
  input wire logic [NPINS-1:0] i_per_out,
  input wire logic [NPINS-1:0] i_pin_in,
  output logic o_reset_pin_oe,
  output logic o_reset_pin_out,
  output logic o_sys_reset,
  output logic [`RMSP_CAUSE_W-1:0] o_reset_cause_register,
  output logic o_background_mode,
  output logic o_debug_active,
  output logic o_debug_line_out,
  output logic o_debug_line_oe,
  output logic o_debug_rx,
  output logic o_dbg_bit_tick,
  output logic o_use_ext_clk,
  output logic [NPINS-1:0] o_pin_out,
  output logic [NPINS-1:0] o_pin_oe,
  output logic [NPINS-1:0] o_pin_pull_en,
  output logic [NPINS-1:0] o_pin_strong,
  output logic [NPINS-1:0] o_pin_slew,
  output logic [NPINS-1:0] o_port_rdata
);
  // Elaboration check: the pin vectors assume a sane pin count
  if (NPINS < 1 || NPINS > 64)
  begin : g_bad_npins
    $error("NPINS out of range");
  end
  localparam logic [5:0] PULSE_LAST = 6'(`RMSP_RST_PULSE_CYC - 1);
  localparam logic [3:0] BIT_LAST = 4'(`RMSP_BIT_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: first stage read only by the second
  logic rpin_s1_q, rpin_s2_q, dpin_s1_q, dpin_s2_q;
  logic [NPINS-1:0] pin_s1_q, pin_s2_q;
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      rpin_s1_q <= 1'b1;
      rpin_s2_q <= 1'b1;
      dpin_s1_q <= 1'b1;
      dpin_s2_q <= 1'b1;
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end
    else
    begin
      rpin_s1_q <= i_reset_pin;
      rpin_s2_q <= rpin_s1_q;
      dpin_s1_q <= i_debug_pin;
      dpin_s2_q <= dpin_s1_q;
      pin_s1_q <= i_pin_in;
      pin_s2_q <= pin_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset sequencer
  rmsp_state_type state_q, state_d;
  logic [5:0] cnt_q, cnt_d;
  logic ext_low;
  logic any_int;
  logic pull_done;
  // Our own pull shows on the pin too; only a low seen while running is external
  assign ext_low = ~rpin_s2_q;
  assign any_int = |i_int_reset;
  assign pull_done = (cnt_q == PULSE_LAST);
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      RMSP_ST_RUN:
      begin
        if (any_int || ext_low)
        begin
          state_d = RMSP_ST_PULL;
          cnt_d = '0;
        end
      end
      RMSP_ST_PULL:
      begin
        cnt_d = cnt_q + 6'h01;
        if (pull_done)
          state_d = RMSP_ST_WAIT;
      end
      RMSP_ST_WAIT:
      begin
        // Hold reset while an outside party keeps the pin low
        if (~ext_low)
          state_d = RMSP_ST_RUN;
      end
      default:
        state_d = RMSP_ST_RUN;
    endcase
  end
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_q <= RMSP_ST_PULL; // Power-up also produces the low pulse
      cnt_q <= 6'h00;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end
  assign o_reset_pin_oe = (state_q == RMSP_ST_PULL);
  assign o_reset_pin_out = 1'b0; // Open drain: drive low only
  assign o_sys_reset = (state_q != RMSP_ST_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // Reset cause: set wins over clear; new reset replaces older cause
  logic [`RMSP_CAUSE_W-1:0] cause_q, cause_new;
  logic cause_evt;
  assign cause_evt = (state_q == RMSP_ST_RUN) && (any_int || ext_low);
  always_comb
  begin
    cause_new = i_int_reset;
    cause_new[`RMSP_CAUSE_EXT] = ext_low & ~any_int;
  end
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      cause_q <= `RMSP_CAUSE_W'(1 << `RMSP_CAUSE_POR);
    else if (cause_evt)
      cause_q <= cause_new;
    else if (i_clear_cause)
      cause_q <= '0;
  end
  assign o_reset_cause_register = cause_q;

  ////////////////////////////////////////////////////////////////////////////
  // Mode select: sampled once, on the cycle reset releases
  logic mode_bkg_q, rel_edge, ext_clk_q;
  assign rel_edge = (state_q != RMSP_ST_RUN) && (state_d == RMSP_ST_RUN);
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      mode_bkg_q <= 1'b0;
    else if (rel_edge)
      mode_bkg_q <= ~dpin_s2_q;
  end
  assign o_background_mode = mode_bkg_q;
  assign o_debug_active = ~o_sys_reset;
  // Clock source: internal after every reset, software may switch later
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      ext_clk_q <= 1'b0;
    else if (o_sys_reset)
      ext_clk_q <= 1'b0;
    else
      ext_clk_q <= i_clk_ext_sel;
  end
  assign o_use_ext_clk = ext_clk_q;

  ////////////////////////////////////////////////////////////////////////////
  // Debug line: bit timing at debug clock, which may equal bus clock
  logic [3:0] bcnt_q;
  logic tx_q, tx_prev_q, spd_q, tx_d;
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      bcnt_q <= 4'h0;
    else if (o_sys_reset)
      bcnt_q <= 4'h0;
    else if (i_dbg_clk_en)
      bcnt_q <= (bcnt_q == BIT_LAST) ? 4'h0 : bcnt_q + 4'h1;
  end
  assign o_dbg_bit_tick = i_dbg_clk_en && (bcnt_q == BIT_LAST);
  // Line is pulled low only while running and sending a low bit
  assign tx_d = ~(o_debug_active & i_dbg_tx_en & ~i_dbg_tx_bit);
  // Speedup pulse starts on the releasing edge, so the pull-up never lifts alone
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      tx_q <= 1'b1;
      tx_prev_q <= 1'b1;
      spd_q <= 1'b0;
    end
    else
    begin
      tx_q <= tx_d;
      tx_prev_q <= tx_q;
      spd_q <= tx_d & ~tx_q;
    end
  end
  assign o_debug_line_out = spd_q;
  assign o_debug_line_oe = ~tx_q | spd_q;
  assign o_debug_rx = dpin_s2_q;

  ////////////////////////////////////////////////////////////////////////////
  // Port pin configuration
  rmsp_pincfg_type cfg_q [NPINS];
  genvar g;
  generate
    for (g = 0; g < NPINS; g++)
    begin : g_pin
      always_ff @(posedge i_mclk or posedge i_rst)
      begin
        if (i_rst)
          cfg_q[g] <= '0;
        else if (i_cfg_we)
          cfg_q[g] <= '{i_cfg_dir[g], i_cfg_drive[g], i_cfg_slew[g], i_cfg_pull[g]};
      end
      assign o_pin_oe[g] = i_per_own[g] ? i_per_oe[g] : cfg_q[g].dir_out;
      assign o_pin_out[g] = i_per_own[g] ? i_per_out[g] : i_port_out[g];
      assign o_pin_strong[g] = o_pin_oe[g] & cfg_q[g].strong_drive;
      assign o_pin_slew[g] = o_pin_oe[g] & cfg_q[g].slew_limit;
      assign o_pin_pull_en[g] = ~o_pin_oe[g] & cfg_q[g].pull_up;
      assign o_port_rdata[g] = cfg_q[g].dir_out ? i_port_out[g] : pin_s2_q[g];
      port_read_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        cfg_q[g].dir_out |-> (o_port_rdata[g] == i_port_out[g]))
        else $error("port read ignores direction");
      per_dir_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        i_per_own[g] |-> (o_pin_oe[g] == i_per_oe[g]))
        else $error("peripheral direction not obeyed");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence s_pull_start;
    (state_q == RMSP_ST_RUN) && (any_int || ext_low);
  endsequence
  rst_pulse_len_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    s_pull_start |=> o_reset_pin_oe [*8] ##26 o_reset_pin_oe ##1 !o_reset_pin_oe)
    else $error("reset pin low pulse length wrong");
  rst_ext_restart_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (state_q == RMSP_ST_RUN && ext_low) |=> o_sys_reset)
    else $error("external reset not honoured");
  cause_record_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (cause_evt && i_int_reset[`RMSP_CAUSE_LVD]) |=> cause_q[`RMSP_CAUSE_LVD])
    else $error("reset cause not recorded");
  mode_sample_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    rel_edge |=> (mode_bkg_q == !$past(dpin_s2_q)))
    else $error("mode select sampled wrongly");
  mode_hold_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (!rel_edge && !$past(rel_edge)) |-> $stable(mode_bkg_q))
    else $error("mode changed outside release");
  bit_time_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (o_dbg_bit_tick && i_dbg_clk_en) |=> (bcnt_q == 4'h0))
    else $error("debug bit counter wrong");
  speedup_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (tx_q && !tx_prev_q) |-> (o_debug_line_oe && o_debug_line_out) ##1 !spd_q)
    else $error("speedup pulse missing");
  int_clock_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_sys_reset |=> !o_use_ext_clk)
    else $error("external clock used in reset");
endmodule : rmsp_core
`default_nettype wire

//--- rmsp_host.sv
// Debug host and reset switch model facing the reset and debug/mode-select pins
`timescale 1ns/1ps
`default_nettype none
module rmsp_host
(
  input wire logic i_rst_oe,
  input wire logic i_dbg_oe,
  input wire logic i_dbg_out,
  input wire logic i_hold_rst,
  input wire logic i_hold_dbg,
  output logic o_reset_pin,
  output logic o_debug_pin
);
  ////////////////////////////////////////////////////////////////////////////////
  // Reset line has a pull-up; the device or the switch may pull it low
  assign o_reset_pin = ~(i_rst_oe | i_hold_rst);
  // Device drive wins; otherwise the host holds it low or the pull-up lifts it
  // Pull-up means a released line never shows a stale level
  assign o_debug_pin = i_dbg_oe ? i_dbg_out : ~i_hold_dbg;
endmodule : rmsp_host
`default_nettype wire

//--- test_reset_mode_select_pin_control.sv
// Self-checking bench for the reset and mode-select pin control block
`timescale 1ns/1ps
`default_nettype none
`include "rmsp_defines.svh"
module test_reset_mode_select_pin_control;
  // Bench drives
  logic i_mclk, i_rst, clk_ext_sel, clear_cause, tx_en, tx_bit, cfg_we, hold_rst, hold_dbg;
  logic [`RMSP_CAUSE_W-1:0] int_reset;
  logic [7:0] cfg_dir, cfg_drive, cfg_slew, cfg_pull, port_out, per_own, per_oe, pin_in;
  // Design outputs and wire levels
  logic rst_oe, sys_reset, bg_mode, dbg_active, dbg_out, dbg_oe, bit_tick, use_ext;
  logic reset_pin, debug_pin, dbg_rx;
  logic [`RMSP_CAUSE_W-1:0] cause;
  logic [7:0] pin_out, pin_oe, pin_pull, pin_strong, pin_slew, port_rdata;
  int miscompares, compares, cycles;
  ////////////////////////////////////////////////////////////////////////////////
  rmsp_core #(.NPINS(8)) i_rmsp_core
  (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_reset_pin(reset_pin), .i_int_reset(int_reset),
    .i_clear_cause(clear_cause), .i_debug_pin(debug_pin), .i_dbg_clk_en(1'b1),
    .i_dbg_tx_en(tx_en), .i_dbg_tx_bit(tx_bit), .i_clk_ext_sel(clk_ext_sel), .i_cfg_we(cfg_we),
    .i_cfg_dir(cfg_dir), .i_cfg_drive(cfg_drive), .i_cfg_slew(cfg_slew),
    .i_cfg_pull(cfg_pull), .i_port_out(port_out), .i_per_own(per_own), .i_per_oe(per_oe),
    .i_per_out(8'h10), .i_pin_in(pin_in), .o_reset_pin_oe(rst_oe), .o_reset_pin_out(),
    .o_sys_reset(sys_reset), .o_reset_cause_register(cause), .o_background_mode(bg_mode),
    .o_debug_active(dbg_active), .o_debug_line_out(dbg_out), .o_debug_line_oe(dbg_oe),
    .o_debug_rx(dbg_rx), .o_dbg_bit_tick(bit_tick), .o_use_ext_clk(use_ext), .o_pin_out(pin_out),
    .o_pin_oe(pin_oe), .o_pin_pull_en(pin_pull), .o_pin_strong(pin_strong),
    .o_pin_slew(pin_slew), .o_port_rdata(port_rdata)
  );
  rmsp_host i_rmsp_host
  (
    .i_rst_oe(rst_oe), .i_dbg_oe(dbg_oe), .i_dbg_out(dbg_out), .i_hold_rst(hold_rst),
    .i_hold_dbg(hold_dbg), .o_reset_pin(reset_pin), .o_debug_pin(debug_pin)
  );
  ////////////////////////////////////////////////////////////////////////////////
  // Clock, 5 ns period
  initial
  begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end
  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge i_mclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      miscompares++;
      $display("Error timeout expected 0 seen 1");
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // One comparison; case inequality so unknowns fail
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Measure one reset pin pulse, wait for the sequence to end, check the cause
  task automatic pulse_chk(input logic [3:0] ecause);
    int n;
    int w;
    n = 0;
    w = 0;
    // Look only once the edge that took the request has settled
    @(negedge i_mclk);
    while (rst_oe !== 1'b1 && w < 50)
    begin
      @(negedge i_mclk);
      w++;
    end
    while (rst_oe === 1'b1 && n < 100)
    begin
      @(negedge i_mclk);
      n++;
    end
    w = 0;
    while (sys_reset !== 1'b0 && w < 100)
    begin
      @(negedge i_mclk);
      w++;
    end
    chk("pulse_len", 8'(`RMSP_RST_PULSE_CYC), 8'(n));
    chk("cause", {4'h0, ecause}, {4'h0, cause});
    chk("sys_reset", 8'h00, {7'h0, sys_reset});
    chk("use_ext", 8'h00, {7'h0, use_ext});
  endtask : pulse_chk
  ////////////////////////////////////////////////////////////////////////////////
  // Defaults once the power-up sequence is over
  task automatic t_after_reset;
    int w;
    w = 0;
    while (sys_reset !== 1'b0 && w < 100)
    begin
      @(negedge i_mclk);
      w++;
    end
    chk("por_cause", 8'h02, {4'h0, cause});
    chk("bg_mode", 8'h00, {7'h0, bg_mode});
    chk("dbg_active", 8'h01, {7'h0, dbg_active});
    chk("use_ext", 8'h00, {7'h0, use_ext});
    chk("pin_oe", 8'h00, pin_oe);
    chk("pin_pull", 8'h00, pin_pull);
    // Software asks for the external clock all along; it is honoured only once running
    @(negedge i_mclk);
    chk("use_ext_sw", 8'h01, {7'h0, use_ext});
    $display("test after_reset done");
  endtask : t_after_reset
  // Each internal source, the last with the host holding the mode pin low
  task automatic t_int_mode;
    for (int b = 1; b < 4; b++)
    begin
      @(posedge i_mclk) clear_cause <= 1'b1;
      @(posedge i_mclk) clear_cause <= 1'b0;
      @(negedge i_mclk);
      chk("cleared", 8'h00, {4'h0, cause});
      @(posedge i_mclk);
      hold_dbg <= (b == 3);
      int_reset <= 4'h1 << b;
      @(posedge i_mclk) int_reset <= 4'h0;
      pulse_chk(4'h1 << b);
      repeat (3) @(negedge i_mclk);
      chk("bg_mode", {7'h0, b == 3}, {7'h0, bg_mode});
      @(posedge i_mclk) hold_dbg <= 1'b0;
    end
    $display("test int_mode done");
  endtask : t_int_mode
  // Switch to ground on the reset pin
  task automatic t_ext_reset;
    // Two cycles of closure pass the synchroniser and end before the own pull starts
    @(posedge i_mclk) hold_rst <= 1'b1;
    repeat (2) @(posedge i_mclk);
    hold_rst <= 1'b0;
    pulse_chk(4'h1);
    chk("bg_mode", 8'h00, {7'h0, bg_mode});
    $display("test ext_reset done");
  endtask : t_ext_reset
  // Pin configuration, peripheral override and port read
  task automatic t_pins;
    @(posedge i_mclk);
    {cfg_we, cfg_dir, cfg_pull, cfg_drive, cfg_slew} <= {1'b1, 8'hF0, 8'h0F, 8'hD0, 8'hD0};
    {port_out, pin_in, per_own, per_oe} <= {8'hA5, 8'h3C, 8'h30, 8'h10};
    @(posedge i_mclk) cfg_we <= 1'b0;
    repeat (4) @(negedge i_mclk);
    chk("pin_oe", 8'hD0, pin_oe);
    chk("pin_out", 8'h95, pin_out);
    chk("pin_pull", 8'h0F, pin_pull);
    chk("pin_strong", 8'hD0, pin_strong);
    chk("pin_slew", 8'hD0, pin_slew);
    chk("port_rdata", 8'hAC, port_rdata);
    $display("test pins done");
  endtask : t_pins
  // Low bit, release with speedup pulse, then bit time ticks
  task automatic t_debug;
    int n;
    n = 0;
    @(posedge i_mclk) {tx_en, tx_bit} <= 2'b10;
    repeat (4) @(negedge i_mclk);
    chk("dbg_low", 8'h00, {7'h0, debug_pin});
    chk("dbg_rx_low", 8'h00, {7'h0, dbg_rx});
    @(posedge i_mclk) tx_bit <= 1'b1;
    repeat (4)
    begin
      @(negedge i_mclk);
      n += (dbg_oe === 1'b1 && dbg_out === 1'b1);
    end
    chk("speedup", 8'h01, 8'(n));
    @(posedge i_mclk) tx_en <= 1'b0;
    n = 0;
    repeat (64)
    begin
      @(negedge i_mclk);
      n += (bit_tick === 1'b1);
    end
    chk("bit_ticks", 8'h04, 8'(n));
    chk("dbg_rx_high", 8'h01, {7'h0, dbg_rx});
    $display("test debug done");
  endtask : t_debug
  // Counts, verdict, stop
  task automatic end_sim;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {i_rst, clk_ext_sel, clear_cause, tx_en, tx_bit, cfg_we, hold_rst, hold_dbg} = 8'hC0;
    {int_reset, cfg_dir, cfg_drive, cfg_slew, cfg_pull} = '0;
    {port_out, per_own, per_oe, pin_in} = '0;
    {miscompares, compares, cycles} = '0;
    repeat (10) @(posedge i_mclk);
    i_rst <= 1'b0;
    t_after_reset();
    t_int_mode();
    t_ext_reset();
    t_pins();
    t_debug();
    end_sim();
  end
endmodule : test_reset_mode_select_pin_control
`default_nettype wire
